// ---- src/ppsr_discharge_chk.sv ----
// per-channel output discharge check that gates entry to the ON state
`timescale 1ns/10ps
module ppsr_discharge_chk
  import ppsr_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire logic [15:0] i_coef,
  input wire logic [15:0] i_vout_cmd,
  input wire logic [15:0] i_vout,
  input wire logic i_on_cmd,
  input wire logic i_clear,
  output logic o_on_permit,
  output logic o_discharge_flag
);
  logic signed [4:0] coef_exp;
  logic signed [10:0] coef_mant;
  logic [5:0] neg_exp;
  logic signed [63:0] prod;
  logic signed [63:0] vout_s;
  logic signed [63:0] mant_s;
  logic below;
  logic gt_one;
  logic ok;
  logic on_prev;
  logic on_rise;

  assign coef_exp = $signed(i_coef[15:11]);
  assign coef_mant = $signed(i_coef[10:0]);
  assign neg_exp = 6'(-$signed({coef_exp[4], coef_exp}));
  // both operands at full width so the product cannot wrap
  assign prod = mant_s * $signed({48'h0, i_vout_cmd});
  assign vout_s = $signed({48'h0, i_vout});
  assign mant_s = 64'(coef_mant);

  // negative exponent scales the measured side up instead of losing bits
  always_comb begin
    if (coef_exp < 0) begin
      below = (vout_s <<< neg_exp) < prod;
      gt_one = mant_s > (64'sh1 <<< neg_exp);
    end else begin
      below = vout_s < (prod <<< 6'(coef_exp));
      gt_one = (mant_s <<< 6'(coef_exp)) > 64'sh1;
    end
  end

  assign ok = gt_one | below;
  assign on_rise = i_on_cmd & ~on_prev;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      on_prev <= 1'b0;
    end else begin
      on_prev <= i_on_cmd;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_on_permit <= 1'b0;
    end else begin
      o_on_permit <= i_on_cmd & ok;
    end
  end

  // flag on undischarged turn-on; set beats clear
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_discharge_flag <= 1'b0;
    end else if (on_rise && !ok) begin
      o_discharge_flag <= 1'b1;
    end else if (i_clear) begin
      o_discharge_flag <= 1'b0;
    end
  end

  sequence s_bad_turn_on;
    i_on_cmd && !on_prev && !ok;
  endsequence

  AST_DISCH_FLAG_SET: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    s_bad_turn_on |=> o_discharge_flag)
    else $error("discharge flag not set on undischarged turn-on");

  AST_HELD_OFF: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (!gt_one && !below) |=> !o_on_permit)
    else $error("channel permitted on above its off threshold");

  AST_CHECK_DISABLED: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (gt_one && i_on_cmd) |=> o_on_permit)
    else $error("coefficient above one still blocks turn-on");
endmodule

// ---- src/ppsr_pkg.sv ----
// shared constants and carrier types of the pad-status read-back bank
package ppsr_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int NUM_CH = 8;
  // share-clock counts as held low after this long without a high level
  localparam int SHCLK_LOW_NS = 20000;
  localparam int SHCLK_LOW_CYC = (SHCLK_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] CMD_PAD_STATE = 8'hd0;
  localparam logic [7:0] CMD_MAKER_ID = 8'hd1;
  localparam logic [7:0] CMD_LOT = 8'hd2;
  localparam logic [7:0] CMD_DISCH_COEF = 8'hd3;
  localparam logic [7:0] CMD_COMMON = 8'hd4;
  localparam logic [7:0] CMD_OEM_DATA = 8'hd5;
  localparam logic [7:0] CMD_USER_UNPAGED = 8'hd6;
  localparam logic [7:0] CMD_USER_PAGED = 8'hd7;

  localparam int PAD_PWRGD_BIT = 15;
  localparam int PAD_ALERT_BIT = 14;
  localparam int PAD_FDRV_LSB = 10;
  localparam int PAD_ADDRESS_SELECT_PIN1_LSB = 8;
  localparam int PAD_ADDRESS_SELECT_PIN0_LSB = 6;
  localparam int PAD_CTRL1_BIT = 5;
  localparam int PAD_CTRL0_BIT = 4;
  localparam int PAD_FIN_LSB = 0;

  localparam int COM_ALERT_BIT = 7;
  localparam int COM_BUSYB_BIT = 6;
  localparam int COM_RSVD_LSB = 2;
  localparam logic [3:0] COM_RSVD_VAL = 4'hf;
  localparam int COM_SHCLK_BIT = 1;
  localparam int COM_WP_BIT = 0;

  localparam logic [1:0] ASEL_HIGH = 2'h3;
  localparam logic [1:0] ASEL_FLOAT = 2'h2;
  localparam logic [1:0] ASEL_LOW = 2'h0;

  // coefficient 0.5 in the 11-bit-mantissa linear format
  localparam logic [15:0] DISCH_COEF_RST = 16'hf801;
  localparam logic [15:0] USER_RST = 16'h0000;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [2:0] page;
    logic [15:0] wdata;
  } ppsr_cmd_t;

  typedef struct packed {
    logic valid;
    logic nack;
    logic [15:0] rdata;
  } ppsr_rsp_t;
endpackage

// ---- src/ppsr_readback.sv ----
// read-back, common status, discharge and scratchpad registers
`timescale 1ns/10ps
module ppsr_readback
  import ppsr_pkg::*;
#(
  parameter logic [15:0] MAKER_ID = 16'h5a5a, // arbitrary value
  parameter logic [7:0] LOT_DEFAULT = 8'h00 // arbitrary value
) (
  input wire logic i_sys_clk,
  input wire logic i_srst,
  input wire ppsr_cmd_t i_cmd,
  output ppsr_rsp_t o_rsp,
  input wire logic [3:0] i_fault_bus_pin,
  input wire logic [3:0] i_fault_bus_drive_low,
  input wire logic i_address_select_pin0_level,
  input wire logic i_address_select_pin0_float,
  input wire logic i_address_select_pin1_level,
  input wire logic i_address_select_pin1_float,
  input wire logic i_control_input0,
  input wire logic i_control_input1,
  input wire logic i_pwrgd_drive_low,
  input wire logic i_alert_req,
  input wire logic i_alertb_in,
  output logic o_alertb_out,
  output logic o_alertb_oe,
  input wire logic i_share_clk_in,
  input wire logic i_write_protect,
  input wire logic i_nvm_busy,
  input wire logic i_clear_faults,
  input wire logic i_store_all,
  input wire logic i_restore_all,
  input wire logic [NUM_CH-1:0] i_on_cmd,
  input wire logic [NUM_CH-1:0][15:0] i_vout_cmd,
  input wire logic [NUM_CH-1:0][15:0] i_vout,
  output logic [NUM_CH-1:0] o_on_permit,
  output logic [NUM_CH-1:0] o_discharge_flag,
  output logic o_busy_flag
);
  logic [15:0] disch_coef [NUM_CH];
  logic [15:0] user_paged [NUM_CH];
  logic [15:0] user_unpaged;
  logic [15:0] oem_data;
  logic [15:0] nvm_user_paged [NUM_CH];
  logic [15:0] nvm_user_unpaged;
  logic [15:0] nvm_oem_data;
  logic [11:0] shclk_low_cnt;
  logic shclk_held_low;
  logic [15:0] pad_word;
  logic [7:0] common_word;
  logic accept;
  logic wr_ok;
  ppsr_rsp_t next_rsp;

  function automatic logic [1:0] asel_code(input logic level, input logic floating);
    if (floating) begin
      return ASEL_FLOAT;
    end
    return level ? ASEL_HIGH : ASEL_LOW;
  endfunction

  function automatic logic is_writable(input logic [7:0] code);
    return (code == CMD_DISCH_COEF) || (code == CMD_OEM_DATA) ||
           (code == CMD_USER_UNPAGED) || (code == CMD_USER_PAGED);
  endfunction

  function automatic logic is_known(input logic [7:0] code);
    return is_writable(code) || (code == CMD_PAD_STATE) || (code == CMD_MAKER_ID) ||
           (code == CMD_LOT) || (code == CMD_COMMON);
  endfunction

  // only the common status read gets through while busy
  assign accept = i_cmd.valid && (!i_nvm_busy || (i_cmd.code == CMD_COMMON && !i_cmd.write));
  assign wr_ok = accept && i_cmd.write && is_writable(i_cmd.code);

  // live at the serve cycle, nothing latched
  always_comb begin
    pad_word = 16'h0000;
    pad_word[PAD_PWRGD_BIT] = ~i_pwrgd_drive_low;
    // alert drive from our own driver flop
    pad_word[PAD_ALERT_BIT] = ~o_alertb_oe;
    pad_word[PAD_FDRV_LSB +: 4] = ~i_fault_bus_drive_low;
    pad_word[PAD_ADDRESS_SELECT_PIN1_LSB +: 2] = asel_code(i_address_select_pin1_level, i_address_select_pin1_float);
    pad_word[PAD_ADDRESS_SELECT_PIN0_LSB +: 2] = asel_code(i_address_select_pin0_level, i_address_select_pin0_float);
    pad_word[PAD_CTRL1_BIT] = i_control_input1;
    pad_word[PAD_CTRL0_BIT] = i_control_input0;
    pad_word[PAD_FIN_LSB +: 4] = i_fault_bus_pin;
  end

  always_comb begin
    common_word = 8'h00;
    common_word[COM_ALERT_BIT] = i_alertb_in;
    common_word[COM_BUSYB_BIT] = ~i_nvm_busy;
    common_word[COM_RSVD_LSB +: 4] = COM_RSVD_VAL;
    common_word[COM_SHCLK_BIT] = shclk_held_low;
    common_word[COM_WP_BIT] = i_write_protect;
  end

  // a stalled share-clock is told apart from a slow one only by this timeout
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      shclk_low_cnt <= 12'h000;
    end else if (i_share_clk_in) begin
      shclk_low_cnt <= 12'h000;
    end else if (!shclk_held_low) begin
      shclk_low_cnt <= shclk_low_cnt + 12'h001;
    end
  end
  assign shclk_held_low = (shclk_low_cnt >= 12'(SHCLK_LOW_CYC));

  always_comb begin
    next_rsp = '0;
    next_rsp.valid = i_cmd.valid;
    if (!accept || !is_known(i_cmd.code) || (i_cmd.write && !is_writable(i_cmd.code))) begin
      next_rsp.nack = i_cmd.valid;
    end else if (!i_cmd.write) begin
      case (i_cmd.code)
        CMD_PAD_STATE: begin
          next_rsp.rdata = pad_word;
        end
        CMD_MAKER_ID: begin
          next_rsp.rdata = MAKER_ID;
        end
        CMD_LOT: begin
          next_rsp.rdata = {8'h00, LOT_DEFAULT};
        end
        CMD_DISCH_COEF: begin
          next_rsp.rdata = disch_coef[i_cmd.page];
        end
        CMD_COMMON: begin
          next_rsp.rdata = {8'h00, common_word};
        end
        CMD_OEM_DATA: begin
          next_rsp.rdata = oem_data;
        end
        CMD_USER_UNPAGED: begin
          next_rsp.rdata = user_unpaged;
        end
        CMD_USER_PAGED: begin
          next_rsp.rdata = user_paged[i_cmd.page];
        end
        default: begin
          next_rsp.rdata = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_rsp <= '0;
    end else begin
      o_rsp <= next_rsp;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_busy_flag <= 1'b0;
    end else if (i_cmd.valid && !accept) begin
      o_busy_flag <= 1'b1;
    end else if (i_clear_faults) begin
      o_busy_flag <= 1'b0;
    end
  end

  // raw linear word kept per page
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      for (int i = 0; i < NUM_CH; i++) begin
        disch_coef[i] <= DISCH_COEF_RST;
      end
    end else if (wr_ok && i_cmd.code == CMD_DISCH_COEF) begin
      disch_coef[i_cmd.page] <= i_cmd.wdata;
    end
  end

  // scratchpad words; restore takes priority over a same-cycle write
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      user_unpaged <= USER_RST;
      oem_data <= USER_RST;
      for (int i = 0; i < NUM_CH; i++) begin
        user_paged[i] <= USER_RST;
      end
    end else if (i_restore_all) begin
      user_unpaged <= nvm_user_unpaged;
      oem_data <= nvm_oem_data;
      for (int i = 0; i < NUM_CH; i++) begin
        user_paged[i] <= nvm_user_paged[i];
      end
    end else if (wr_ok) begin
      case (i_cmd.code)
        CMD_USER_UNPAGED: begin
          user_unpaged <= i_cmd.wdata;
        end
        CMD_OEM_DATA: begin
          oem_data <= i_cmd.wdata;
        end
        CMD_USER_PAGED: begin
          user_paged[i_cmd.page] <= i_cmd.wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // save the live words; image survives only as a stand-in for the store
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      nvm_user_unpaged <= USER_RST;
      nvm_oem_data <= USER_RST;
      for (int i = 0; i < NUM_CH; i++) begin
        nvm_user_paged[i] <= USER_RST;
      end
    end else if (i_store_all) begin
      nvm_user_unpaged <= user_unpaged;
      nvm_oem_data <= oem_data;
      for (int i = 0; i < NUM_CH; i++) begin
        nvm_user_paged[i] <= user_paged[i];
      end
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_chan
      ppsr_discharge_chk u_chk (
        .i_sys_clk(i_sys_clk),
        .i_srst(i_srst),
        .i_coef(disch_coef[ch]),
        .i_vout_cmd(i_vout_cmd[ch]),
        .i_vout(i_vout[ch]),
        .i_on_cmd(i_on_cmd[ch]),
        .i_clear(i_clear_faults),
        .o_on_permit(o_on_permit[ch]),
        .o_discharge_flag(o_discharge_flag[ch])
      );
    end
  endgenerate

  // open-drain alert pulled while any discharge flag stands
  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      o_alertb_oe <= 1'b0;
      o_alertb_out <= 1'b0;
    end else begin
      o_alertb_oe <= i_alert_req | (|o_discharge_flag);
      o_alertb_out <= 1'b0;
    end
  end

  sequence s_rd(logic [7:0] rd_code);
    i_cmd.valid && !i_cmd.write && i_cmd.code == rd_code && !i_nvm_busy;
  endsequence

  AST_PAD_PWRGD: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    s_rd(CMD_PAD_STATE) |=> o_rsp.rdata[PAD_PWRGD_BIT] == !$past(i_pwrgd_drive_low))
    else $error("pad power-good drive bit wrong");

  AST_PAD_ALERT: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    s_rd(CMD_PAD_STATE) |=> o_rsp.rdata[PAD_ALERT_BIT] == !$past(o_alertb_oe))
    else $error("pad alert drive bit wrong");

  AST_PAD_FDRV: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    s_rd(CMD_PAD_STATE) |=> o_rsp.rdata[13:10] == ~$past(i_fault_bus_drive_low))
    else $error("pad fault-bus drive field wrong");

  AST_PAD_ASEL: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    s_rd(CMD_PAD_STATE) ##0 i_address_select_pin1_float |=> o_rsp.rdata[9:8] == ASEL_FLOAT)
    else $error("floating address select misreported");

  AST_PAD_LEVELS: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    s_rd(CMD_PAD_STATE) |=> o_rsp.valid && !o_rsp.nack &&
      o_rsp.rdata[5:0] == {$past(i_control_input1), $past(i_control_input0), $past(i_fault_bus_pin)})
    else $error("pad input levels wrong");

  AST_MAKER_ID: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    s_rd(CMD_MAKER_ID) |=> o_rsp.rdata == MAKER_ID && !o_rsp.nack)
    else $error("maker identification wrong");

  AST_COMMON_WHILE_BUSY: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (i_cmd.valid && !i_cmd.write && i_cmd.code == CMD_COMMON && i_nvm_busy)
      |=> o_rsp.valid && !o_rsp.nack && !o_rsp.rdata[COM_BUSYB_BIT] && o_rsp.rdata[5:2] == COM_RSVD_VAL)
    else $error("common status not served while busy");

  AST_BUSY_NACK: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (i_cmd.valid && i_nvm_busy && i_cmd.code != CMD_COMMON) |=> o_rsp.nack && o_busy_flag)
    else $error("busy device did not refuse command");

  AST_DISCH_ALERT: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (|o_discharge_flag) |=> o_alertb_oe)
    else $error("alert not pulled on discharge flag");

  AST_COMMON_BITS: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    s_rd(CMD_COMMON) |=> o_rsp.rdata[COM_ALERT_BIT] == $past(i_alertb_in) &&
      o_rsp.rdata[COM_SHCLK_BIT] == $past(shclk_held_low) && o_rsp.rdata[COM_WP_BIT] == $past(i_write_protect))
    else $error("common status pin bits wrong");

  AST_LOT_VALUE: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    s_rd(CMD_LOT) |=> o_rsp.rdata == {8'h00, LOT_DEFAULT} && !o_rsp.nack)
    else $error("lot number wrong");

  AST_RO_WRITE_NACK: assert property (@(posedge i_sys_clk) disable iff (i_srst)
    (i_cmd.valid && i_cmd.write && i_cmd.code == CMD_PAD_STATE) |=> o_rsp.nack)
    else $error("write to pad register not refused");
endmodule

// ---- tb/ppsr_host_model.sv ----
// host-side command source and answer catcher for the read-back bank
`timescale 1ns/10ps
module ppsr_host_model
  import ppsr_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_req,
  input wire logic i_write,
  input wire logic [7:0] i_code,
  input wire logic [2:0] i_page,
  input wire logic [15:0] i_wdata,
  input wire ppsr_rsp_t i_rsp,
  output ppsr_cmd_t o_cmd,
  output logic o_done,
  output logic o_nack,
  output logic [15:0] o_rdata
);
  initial o_cmd = '0;
  initial o_done = 1'b0;
  // idle fields invert on every idle cycle, alternating between the last request and its inverse
  always @(posedge i_sys_clk) begin
    if (i_req) begin
      o_cmd <= '{valid: 1'b1, write: i_write, code: i_code, page: i_page, wdata: i_wdata};
    end else begin
      o_cmd <= {1'b0, ~o_cmd[27:0]};
    end
  end
  // answer is taken at the edge where it is valid
  always @(posedge i_sys_clk) begin
    o_done <= i_rsp.valid;
    if (i_rsp.valid) begin
      o_nack <= i_rsp.nack;
      o_rdata <= i_rsp.rdata;
    end
  end
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the pad-status read-back bank
`timescale 1ns/10ps
module tb_top;
  import ppsr_pkg::*;
  localparam logic [15:0] ID_VAL = 16'h3c96; // arbitrary value
  localparam logic [7:0] LOT_VAL = 8'h2b; // arbitrary value
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic req = 1'b0, wr = 1'b0;
  logic [7:0] code = 8'h00;
  logic [2:0] page = 3'h0;
  logic [15:0] wdata = 16'h0000;
  ppsr_cmd_t cmd;
  ppsr_rsp_t rsp;
  logic done, nack, oe, aout, bflag;
  logic [15:0] rdata;
  logic [3:0] fbp = 4'h0, fdrv = 4'h0;
  logic a0l = 0, a0f = 0, a1l = 0, a1f = 0, c0 = 0, c1 = 0, pg = 0, areq = 0, ext_alert = 0;
  logic wp = 0, busy = 0, clr = 0, sto = 0, rcl = 0, shrun = 1, shclk = 0;
  logic [NUM_CH-1:0] on_cmd = '0;
  logic [NUM_CH-1:0][15:0] vcmd = '0, vout = '0;
  logic [NUM_CH-1:0] permit, dflag;
  // open-drain alert wire: low if the chip or anyone else pulls
  wire logic alert_w = ~(oe | ext_alert);
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;

  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) shclk <= shrun ? ~shclk : 1'b0;

  ppsr_host_model host (.i_sys_clk(sys_clk), .i_req(req), .i_write(wr), .i_code(code), .i_page(page),
    .i_wdata(wdata), .i_rsp(rsp), .o_cmd(cmd), .o_done(done), .o_nack(nack), .o_rdata(rdata));

  ppsr_readback #(.MAKER_ID(ID_VAL), .LOT_DEFAULT(LOT_VAL)) dut (.i_sys_clk(sys_clk), .i_srst(srst),
    .i_cmd(cmd), .o_rsp(rsp), .i_fault_bus_pin(fbp), .i_fault_bus_drive_low(fdrv),
    .i_address_select_pin0_level(a0l), .i_address_select_pin0_float(a0f),
    .i_address_select_pin1_level(a1l), .i_address_select_pin1_float(a1f),
    .i_control_input0(c0), .i_control_input1(c1), .i_pwrgd_drive_low(pg), .i_alert_req(areq),
    .i_alertb_in(alert_w), .o_alertb_out(aout), .o_alertb_oe(oe), .i_share_clk_in(shclk),
    .i_write_protect(wp), .i_nvm_busy(busy), .i_clear_faults(clr), .i_store_all(sto),
    .i_restore_all(rcl), .i_on_cmd(on_cmd), .i_vout_cmd(vcmd), .i_vout(vout),
    .o_on_permit(permit), .o_discharge_flag(dflag), .o_busy_flag(bflag));

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      $display("wrong value at %0t: run hung", $time);
      bad_count = bad_count + 1;
      final_report();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
      bad_count++;
    end
  endtask

  task automatic op(input logic w, input logic [7:0] c, input logic [2:0] p, input logic [15:0] d,
                    input logic [15:0] e, input logic en);
    int n;
    @(posedge sys_clk);
    req <= 1'b1;
    wr <= w;
    code <= c;
    page <= p;
    wdata <= d;
    @(posedge sys_clk);
    req <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (done !== 1'b1 && n < 8);
    chk({15'h0, done}, 16'h1, "answer");
    chk({15'h0, nack}, {15'h0, en}, "refusal");
    chk(rdata, e, "data");
  endtask

  // sel 0 clear, 1 store, 2 restore
  task automatic pulse(input int sel);
    @(posedge sys_clk);
    {clr, sto, rcl} <= 3'b100 >> sel;
    @(posedge sys_clk);
    {clr, sto, rcl} <= 3'b000;
    @(posedge sys_clk);
  endtask

  task automatic scr(input logic w, input logic [15:0] base);
    logic [7:0] c;
    logic [15:0] v;
    for (int k = 0; k < 10; k++) begin
      c = (k < 8) ? CMD_USER_PAGED : ((k == 8) ? CMD_USER_UNPAGED : CMD_OEM_DATA);
      v = base ^ (16'h1111 * 16'(k));
      op(w, c, k[2:0], w ? v : 16'h0, w ? 16'h0 : v, 1'b0);
    end
  endtask

  function automatic logic [1:0] asel(input logic l, input logic f);
    return f ? 2'b10 : (l ? 2'b11 : 2'b00);
  endfunction

  function automatic logic [15:0] pad_exp();
    return {~pg, ~areq, ~fdrv, asel(a1l, a1f), asel(a0l, a0f), c1, c0, fbp};
  endfunction

  function automatic logic [15:0] com_exp(input logic held);
    return {8'h00, ~(areq | ext_alert), ~busy, 4'hf, held, wp};
  endfunction

  initial begin
    logic [7:0] ro [5];
    ro = '{CMD_PAD_STATE, CMD_MAKER_ID, CMD_LOT, CMD_COMMON, 8'hd8};
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    #1 chk({rsp.valid, oe, aout, permit}, 16'h0, "reset state");
    op(1'b0, CMD_DISCH_COEF, 3'h0, 16'h0, 16'hf801, 1'b0);
    for (int i = 0; i < 3; i++) begin
      @(posedge sys_clk);
      fbp <= 4'ha ^ 4'(i);
      fdrv <= 4'h3 << i;
      {a0l, a0f, a1l, a1f} <= {i[0], i == 2, ~i[0], i == 1};
      {c0, c1, pg, areq} <= {i[0], ~i[0], i[0], i[1]};
      repeat (2) @(posedge sys_clk);
      #1 chk({15'h0, oe}, {15'h0, areq}, "alert drive");
      op(1'b0, CMD_PAD_STATE, 3'h0, 16'h0, pad_exp(), 1'b0);
    end
    areq <= 1'b0;
    for (int k = 0; k < 5; k++) op(k != 4, ro[k], 3'h0, 16'hffff, 16'h0, 1'b1);
    op(1'b0, CMD_MAKER_ID, 3'h0, 16'h0, ID_VAL, 1'b0);
    op(1'b0, CMD_LOT, 3'h0, 16'h0, {8'h00, LOT_VAL}, 1'b0);
    op(1'b0, CMD_LOT, 3'h7, 16'h0, {8'h00, LOT_VAL}, 1'b0);
    for (int j = 0; j < 2; j++) begin
      @(posedge sys_clk);
      wp <= j[0];
      ext_alert <= ~j[0];
      repeat (2) @(posedge sys_clk);
      op(1'b0, CMD_COMMON, 3'h0, 16'h0, com_exp(1'b0), 1'b0);
    end
    shrun <= 1'b0;
    repeat (4010) @(posedge sys_clk);
    op(1'b0, CMD_COMMON, 3'h0, 16'h0, com_exp(1'b1), 1'b0);
    shrun <= 1'b1;
    repeat (3) @(posedge sys_clk);
    op(1'b0, CMD_COMMON, 3'h0, 16'h0, com_exp(1'b0), 1'b0);
    busy <= 1'b1;
    repeat (2) @(posedge sys_clk);
    op(1'b0, CMD_COMMON, 3'h0, 16'h0, com_exp(1'b0), 1'b0);
    op(1'b0, CMD_PAD_STATE, 3'h0, 16'h0, 16'h0, 1'b1);
    chk({15'h0, bflag}, 16'h1, "busy flag");
    busy <= 1'b0;
    pulse(0);
    #1 chk({15'h0, bflag}, 16'h0, "busy cleared");
    scr(1'b1, 16'hc3a0);
    scr(1'b0, 16'hc3a0);
    pulse(1);
    scr(1'b1, 16'h5a0f);
    pulse(2);
    scr(1'b0, 16'hc3a0);
    // output still at 800 against a 500 threshold
    @(posedge sys_clk);
    vcmd[0] <= 16'd1000;
    vout[0] <= 16'd800;
    on_cmd[0] <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 chk({dflag[0], permit[0], oe}, 16'h5, "discharge held");
    vout[0] <= 16'd400;
    repeat (2) @(posedge sys_clk);
    #1 chk({15'h0, permit[0]}, 16'h1, "discharged on");
    on_cmd[0] <= 1'b0;
    pulse(0);
    op(1'b1, CMD_DISCH_COEF, 3'h0, 16'h0803, 16'h0, 1'b0);
    op(1'b0, CMD_DISCH_COEF, 3'h0, 16'h0, 16'h0803, 1'b0);
    vout[0] <= 16'd800;
    on_cmd[0] <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 chk({dflag[0], permit[0]}, 16'h1, "check disabled");
    final_report();
  end
endmodule
